// >>> logic/msr_readback.sv
// Purpose: Answers the engine advanced settings and border settings queries,
//          and applies the border settings to limit detection and motor stop
// Assumes: Byte stream in and out with valid/ready, synchronous to MCLK_I
// Notes:   Unknown four-byte codes are dropped silently; no answer is sent
`timescale 1ns/1ps
`include "msr_defs.svh"

module msr_readback (
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  // Command bytes from host
  input  wire logic [7:0]  RX_DATA_I,
  input  wire logic        RX_VALID_I,
  output logic             RX_READY_O,
  // Answer bytes to host
  output logic      [7:0]  TX_DATA_O,
  output logic             TX_VALID_O,
  input  wire logic        TX_READY_I,
  // Engine advanced settings load
  input  wire logic        ENG_LOAD_I,
  input  wire logic [15:0] SPEED_MIX_RATIO_I,
  input  wire logic [15:0] POS_GAIN_LOW_SPEED_I,
  input  wire logic [15:0] POS_GAIN_HIGH_SPEED_I,
  // Border settings load
  input  wire logic        BRD_LOAD_I,
  input  wire logic [7:0]  TRAVEL_LIMIT_FLAGS_I,
  input  wire logic [7:0]  LIMIT_SWITCH_FLAGS_I,
  input  wire logic [31:0] LEFT_LIMIT_POSITION_I,
  input  wire logic [15:0] LEFT_LIMIT_MICROSTEPS_I,
  input  wire logic [31:0] RIGHT_LIMIT_POSITION_I,
  input  wire logic [15:0] RIGHT_LIMIT_MICROSTEPS_I,
  // Motion state
  input  wire logic [31:0] POSITION_I,
  input  wire logic [15:0] POSITION_MICROSTEPS_I,
  input  wire logic        LIMIT_INPUT_ONE_I,
  input  wire logic        LIMIT_INPUT_TWO_I,
  // Limit status
  output logic             AT_LEFT_LIMIT_O,
  output logic             AT_RIGHT_LIMIT_O,
  output logic             STOP_MOTOR_O
);

  //////////////////////////////////////////////////////////////////////////////
  // Stored settings
  logic [15:0] mix_ff, gain_lo_ff, gain_hi_ff;
  logic [7:0]  tlf_ff, lsf_ff;
  logic [31:0] left_pos_ff, right_pos_ff;
  logic [15:0] left_us_ff, right_us_ff;
  logic        mix_ok;

  // Out-of-range mixing ratio is refused so the stored value stays legal
  assign mix_ok = (SPEED_MIX_RATIO_I <= `MSR_MIX_MAX);

  // Engine settings with documented defaults after reset
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      mix_ff     <= `MSR_MIX_DEFAULT;
      gain_lo_ff <= `MSR_GAIN_LOW_DEFAULT;
      gain_hi_ff <= `MSR_GAIN_HI_DEFAULT;
    end else if (ENG_LOAD_I) begin
      if (mix_ok) begin
        mix_ff <= SPEED_MIX_RATIO_I;
      end
      gain_lo_ff <= POS_GAIN_LOW_SPEED_I;
      gain_hi_ff <= POS_GAIN_HIGH_SPEED_I;
    end
  end

  // Border settings, all zero after reset
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      tlf_ff       <= 8'h00;
      lsf_ff       <= 8'h00;
      left_pos_ff  <= 32'h0000_0000;
      left_us_ff   <= 16'h0000;
      right_pos_ff <= 32'h0000_0000;
      right_us_ff  <= 16'h0000;
    end else if (BRD_LOAD_I) begin
      tlf_ff       <= TRAVEL_LIMIT_FLAGS_I;
      lsf_ff       <= LIMIT_SWITCH_FLAGS_I;
      left_pos_ff  <= LEFT_LIMIT_POSITION_I;
      left_us_ff   <= LEFT_LIMIT_MICROSTEPS_I;
      right_pos_ff <= RIGHT_LIMIT_POSITION_I;
      right_us_ff  <= RIGHT_LIMIT_MICROSTEPS_I;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Border detection and stop
  logic sw_one_act, sw_two_act, left_sw, right_sw;
  logic left_cnt, right_cnt, at_left, at_right;
  logic stop_left_en, stop_right_en, guard;

  // Polarity per input, then placement of the first switch
  assign sw_one_act = LIMIT_INPUT_ONE_I ^ lsf_ff[`MSR_LSF_ONE_LOW];
  assign sw_two_act = LIMIT_INPUT_TWO_I ^ lsf_ff[`MSR_LSF_TWO_LOW];
  assign left_sw    = lsf_ff[`MSR_LSF_FIRST_RIGHT] ? sw_two_act : sw_one_act;
  assign right_sw   = lsf_ff[`MSR_LSF_FIRST_RIGHT] ? sw_one_act : sw_two_act;

  // Count-mode borders compare whole steps first, then microsteps
  assign left_cnt  = ($signed(POSITION_I) < $signed(left_pos_ff)) ||
                     ((POSITION_I == left_pos_ff) &&
                      ($signed(POSITION_MICROSTEPS_I) <= $signed(left_us_ff)));
  assign right_cnt = ($signed(POSITION_I) > $signed(right_pos_ff)) ||
                     ((POSITION_I == right_pos_ff) &&
                      ($signed(POSITION_MICROSTEPS_I) >= $signed(right_us_ff)));
  assign at_left   = tlf_ff[`MSR_TLF_FROM_COUNTS] ? left_cnt  : left_sw;
  assign at_right  = tlf_ff[`MSR_TLF_FROM_COUNTS] ? right_cnt : right_sw;

  // Each side stops on its own enable; the guard enables both
  assign guard         = tlf_ff[`MSR_TLF_SWAP_GUARD];
  assign stop_left_en  = tlf_ff[`MSR_TLF_STOP_LEFT]  | guard;
  assign stop_right_en = tlf_ff[`MSR_TLF_STOP_RIGHT] | guard;

  // Registered status outputs
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      AT_LEFT_LIMIT_O  <= 1'b0;
      AT_RIGHT_LIMIT_O <= 1'b0;
      STOP_MOTOR_O     <= 1'b0;
    end else begin
      AT_LEFT_LIMIT_O  <= at_left;
      AT_RIGHT_LIMIT_O <= at_right;
      STOP_MOTOR_O     <= (stop_left_en & at_left) | (stop_right_en & at_right);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command collection
  msr_pkg::msr_state_t  state_ff, nxt_state;
  msr_pkg::msr_answer_t ans_ff;
  logic [31:0] cmd_ff, cmd_full;
  logic [2:0]  rx_cnt_ff;
  logic [5:0]  idx_ff, nxt_idx, frame_len;
  logic        rx_take, last_rx, hit_eng, hit_brd, hit, tx_take, last_tx;
  logic [7:0]  nxt_byte, body_byte;
  logic [191:0] body_eng, body_brd;
  logic [15:0] crc_q, crc_nxt;
  logic        crc_en;

  // Bytes arrive low byte first; the fourth byte completes the code
  assign RX_READY_O = (state_ff == msr_pkg::ST_COLLECT);
  assign rx_take    = RX_VALID_I & RX_READY_O;
  assign last_rx    = rx_take && (rx_cnt_ff == (`MSR_REQ_LEN - 3'h1));
  assign cmd_full   = {RX_DATA_I, cmd_ff[31:8]};
  assign hit_eng    = last_rx && (cmd_full == `MSR_CMD_ENG_ADV);
  assign hit_brd    = last_rx && (cmd_full == `MSR_CMD_BORDER);
  assign hit        = hit_eng | hit_brd;

  // Answer bodies, little endian, reserved bytes zero; checksum appended later
  assign body_eng = {112'h0, gain_hi_ff, gain_lo_ff, mix_ff,
                     `MSR_CMD_ENG_ADV};
  assign body_brd = {48'h0, right_us_ff, right_pos_ff, left_us_ff, left_pos_ff,
                     lsf_ff, tlf_ff, `MSR_CMD_BORDER};

  // Byte k of a body vector
  function automatic logic [7:0] pick_byte(input logic [191:0] body, input logic [5:0] k);
    logic [191:0] sh;
    sh = body >> {k, 3'h0};
    return sh[7:0];
  endfunction : pick_byte

  //////////////////////////////////////////////////////////////////////////////
  // Answer sequencing
  assign frame_len = (ans_ff == msr_pkg::ANS_ENG_ADV) ? `MSR_LEN_ENG_ADV : `MSR_LEN_BORDER;
  assign TX_VALID_O = (state_ff == msr_pkg::ST_SEND);
  assign tx_take    = TX_VALID_O & TX_READY_I;
  assign last_tx    = tx_take && (idx_ff == (frame_len - 6'h01));
  assign nxt_idx    = idx_ff + 6'h01;
  assign body_byte  = (ans_ff == msr_pkg::ANS_ENG_ADV) ? pick_byte(body_eng, nxt_idx)
                                                       : pick_byte(body_brd, nxt_idx);
  // Checksum covers every byte before it, code included, low byte sent first
  // The last body byte is folded in too, so the high half sent later is complete
  assign crc_en     = tx_take && (nxt_idx < (frame_len - 6'h01));
  assign nxt_byte   = (nxt_idx == (frame_len - 6'h02)) ? crc_nxt[7:0] :
                      (nxt_idx == (frame_len - 6'h01)) ? crc_q[15:8]  : body_byte;

  msr_crc16 u_crc (
    .clk_i     (MCLK_I),
    .rst_n_i   (RST_N_I),
    .clr_i     (hit),
    .en_i      (crc_en),
    .byte_i    (TX_DATA_O),
    .crc_o     (crc_q),
    .crc_nxt_o (crc_nxt)
  );

  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      msr_pkg::ST_COLLECT: begin
        if (hit) begin
          nxt_state = msr_pkg::ST_SEND;
        end
      end
      msr_pkg::ST_SEND: begin
        if (last_tx) begin
          nxt_state = msr_pkg::ST_COLLECT;
        end
      end
    endcase
  end

  // Sequencer registers; request is taken only while no answer is pending
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state_ff  <= msr_pkg::ST_COLLECT;
      ans_ff    <= msr_pkg::ANS_ENG_ADV;
      cmd_ff    <= 32'h0000_0000;
      rx_cnt_ff <= 3'h0;
      idx_ff    <= 6'h00;
      TX_DATA_O <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (rx_take) begin
        cmd_ff    <= cmd_full;
        rx_cnt_ff <= last_rx ? 3'h0 : rx_cnt_ff + 3'h1;
      end
      if (hit) begin
        ans_ff    <= hit_eng ? msr_pkg::ANS_ENG_ADV : msr_pkg::ANS_BORDER;
        idx_ff    <= 6'h00;
        TX_DATA_O <= cmd_full[7:0];  // Echo begins with the code's low byte
      end else if (tx_take) begin
        idx_ff    <= nxt_idx;
        TX_DATA_O <= nxt_byte;
      end
    end
  end

endmodule : msr_readback

// >>> logic/msr_defs.svh
// Purpose: Constants for the motion settings readback block
// Assumes: Byte-wide command channel, little-endian multi-byte fields
// Notes:   Definitions only; included by bare name
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH

// Command codes as 32-bit words, first byte on the wire is the low byte
`define MSR_CMD_ENG_ADV      32'h73616567
`define MSR_CMD_BORDER       32'h73646567
`define MSR_REQ_LEN          3'h4
// Answer frame lengths in bytes
`define MSR_LEN_ENG_ADV      6'h36
`define MSR_LEN_BORDER       6'h1A
// Engine advanced setting limits and reset values
`define MSR_MIX_MAX          16'h0064
`define MSR_MIX_DEFAULT      16'h0032
`define MSR_GAIN_LOW_DEFAULT 16'h03E8
`define MSR_GAIN_HI_DEFAULT  16'h0021
// Travel limit flag bit positions
`define MSR_TLF_FROM_COUNTS  0
`define MSR_TLF_STOP_LEFT    1
`define MSR_TLF_STOP_RIGHT   2
`define MSR_TLF_SWAP_GUARD   3
// Limit switch flag bit positions
`define MSR_LSF_FIRST_RIGHT  0
`define MSR_LSF_ONE_LOW      1
`define MSR_LSF_TWO_LOW      2
// Checksum: reflected polynomial and seed
`define MSR_CRC_POLY         16'hA001
`define MSR_CRC_SEED         16'hFFFF

`endif

// >>> logic/msr_pkg.sv
// Purpose: Types shared by the motion settings readback block
// Assumes: Used with msr_defs.svh
// Notes:   Nothing here is imported; users write msr_pkg::name
package msr_pkg;

  // Receive/transmit sequencer
  typedef enum logic [0:0] {
    ST_COLLECT,
    ST_SEND
  } msr_state_t;

  // Which answer is being sent
  typedef enum logic [0:0] {
    ANS_ENG_ADV,
    ANS_BORDER
  } msr_answer_t;

endpackage : msr_pkg

// >>> logic/msr_crc16.sv
// Purpose: Running 16-bit checksum over answer bytes
// Assumes: One byte per enable, seed loaded by clear
// Notes:   Next value is exposed so the sender can use it without a bubble
`timescale 1ns/1ps
`include "msr_defs.svh"

module msr_crc16 (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Control
  input  wire logic        clr_i,
  input  wire logic        en_i,
  input  wire logic [7:0]  byte_i,
  // Result
  output logic      [15:0] crc_o,
  output logic      [15:0] crc_nxt_o
);

  logic [15:0] crc_ff;

  // Bitwise reflected update, one byte at a time
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MSR_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  assign crc_nxt_o = crc_step(crc_ff, byte_i);
  assign crc_o     = crc_ff;

  // Clear wins over update so a new frame always starts from the seed
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clr_i) begin
      crc_ff <= `MSR_CRC_SEED;
    end else if (en_i) begin
      crc_ff <= crc_nxt_o;
    end
  end

endmodule : msr_crc16

// >>> dv/msr_readback_asserts.sv
// Purpose: Port-level checks for msr_readback
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every msr_readback instance
`timescale 1ns/1ps
module msr_readback_asserts (
  // Clock and reset
  input wire logic       MCLK_I,
  input wire logic       RST_N_I,
  // Byte channels
  input wire logic       RX_VALID_I,
  input wire logic       RX_READY_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic       TX_VALID_O,
  input wire logic       TX_READY_I,
  // Limit status
  input wire logic       AT_LEFT_LIMIT_O,
  input wire logic       AT_RIGHT_LIMIT_O,
  input wire logic       STOP_MOTOR_O
);
  logic [5:0] cnt_ff;

  // Bytes accepted in the current frame; cleared between frames
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I || !TX_VALID_O)
      cnt_ff <= 6'h00;
    else if (TX_READY_I)
      cnt_ff <= cnt_ff + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_held;
    TX_VALID_O && !TX_READY_I;
  endsequence
  sequence s_last_eng;
    TX_VALID_O && TX_READY_I && cnt_ff == 6'h35;
  endsequence

  a_ready_idle: assert property (RX_READY_O == !TX_VALID_O)
    else $error("request and answer channels both open");
  a_data_holds: assert property (s_held |=> TX_VALID_O && $stable(TX_DATA_O))
    else $error("answer byte changed before it was taken");
  a_first_code: assert property ($rose(TX_VALID_O) |-> TX_DATA_O == 8'h67)
    else $error("answer does not open with the code byte");
  a_answer_cause: assert property ($rose(TX_VALID_O) |-> $past(RX_VALID_I) && $past(RX_READY_O))
    else $error("answer started without a request byte");
  a_frame_length: assert property ($fell(TX_VALID_O) |-> cnt_ff == 6'h36 || cnt_ff == 6'h1A)
    else $error("answer frame of wrong length");
  a_frame_continues: assert property (TX_VALID_O && cnt_ff < 6'h19 |=> TX_VALID_O)
    else $error("answer frame cut short");
  a_frame_ends: assert property (s_last_eng |=> !TX_VALID_O)
    else $error("answer ran past 54 bytes");
  a_stop_at_limit: assert property (STOP_MOTOR_O |-> AT_LEFT_LIMIT_O || AT_RIGHT_LIMIT_O)
    else $error("stop without a reached border");
endmodule : msr_readback_asserts

bind msr_readback msr_readback_asserts u_msr_readback_asserts (.MCLK_I, .RST_N_I,
  .RX_VALID_I, .RX_READY_O, .TX_DATA_O, .TX_VALID_O, .TX_READY_I,
  .AT_LEFT_LIMIT_O, .AT_RIGHT_LIMIT_O, .STOP_MOTOR_O);

// >>> dv/msr_host_model.sv
// Purpose: Host side of the command channel
// Assumes: Signals change at the falling edge only
// Notes:   Released data line shows the inverse of the last byte
`timescale 1ns/1ps
module msr_host_model (
  // Clock
  input  wire logic       clk_i,
  // Request channel
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  // Answer channel
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o
);
  logic [7:0] ans [$];

  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end

  // Four request bytes low first, then collect the answer; slow stalls every other cycle
  task automatic query(input logic [31:0] code, input bit slow);
    ans.delete();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      rx_data_o = code[8*i+:8];
      rx_valid_o = 1'b1;
      while (!rx_ready_i) @(negedge clk_i);
      @(posedge clk_i);
    end
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_i);
      if (i == 0)
        rx_data_o = ~rx_data_o;
      rx_valid_o = 1'b0;
      if (!tx_valid_i && (ans.size() > 0 || i > 20))
        break;
      tx_ready_o = !slow || i[0];
      if (tx_valid_i && tx_ready_o)
        ans.push_back(tx_data_i);
    end
    tx_ready_o = 1'b0;
  endtask : query
endmodule : msr_host_model

// >>> dv/testbench.sv
// Purpose: Self-checking bench for msr_readback
// Assumes: Inputs change at the falling edge
// Notes:   Checksum expectation is recomputed here byte by byte
`timescale 1ns/1ps
`include "msr_defs.svh"
module testbench;
  logic        MCLK_I = 1'b0;
  logic        RST_N_I = 1'b0;
  logic [7:0]  rx_data, tx_data;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, at_l, at_r, stop;
  logic        eng_ld = 1'b0, brd_ld = 1'b0, in_one = 1'b0, in_two = 1'b0;
  logic [15:0] mix = 16'h0000, glo = 16'h0000, ghi = 16'h0000, pus = 16'h0000;
  logic [7:0]  tlf = 8'h00, lsf = 8'h00;
  logic [31:0] pos = 32'h0, lpos = 32'hFFFFFF9C, rpos = 32'h00000064;
  logic [15:0] lus = 16'h8001, rus = 16'h7FFF;
  int          num_errors = 0, samples_checked = 0, cycles = 0;

  always #50 MCLK_I = ~MCLK_I;

  msr_readback u_msr_readback (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
    .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready),
    .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready),
    .ENG_LOAD_I(eng_ld), .SPEED_MIX_RATIO_I(mix), .POS_GAIN_LOW_SPEED_I(glo),
    .POS_GAIN_HIGH_SPEED_I(ghi), .BRD_LOAD_I(brd_ld), .TRAVEL_LIMIT_FLAGS_I(tlf),
    .LIMIT_SWITCH_FLAGS_I(lsf), .LEFT_LIMIT_POSITION_I(lpos), .LEFT_LIMIT_MICROSTEPS_I(lus),
    .RIGHT_LIMIT_POSITION_I(rpos), .RIGHT_LIMIT_MICROSTEPS_I(rus), .POSITION_I(pos),
    .POSITION_MICROSTEPS_I(pus), .LIMIT_INPUT_ONE_I(in_one), .LIMIT_INPUT_TWO_I(in_two),
    .AT_LEFT_LIMIT_O(at_l), .AT_RIGHT_LIMIT_O(at_r), .STOP_MOTOR_O(stop));

  msr_host_model u_msr_host_model (.clk_i(MCLK_I), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge MCLK_I) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_val

  // Code echo, payload, zero fill, then CRC low byte first
  task automatic expect_frame(input logic [31:0] code, input logic [7:0] pl [$], input int len);
    logic [7:0]  e [$];
    logic [15:0] c;
    e = {code[7:0], code[15:8], code[23:16], code[31:24], pl};
    while (e.size() < len - 2) e.push_back(8'h00);
    c = `MSR_CRC_SEED;
    foreach (e[k]) begin
      c = c ^ {8'h00, e[k]};
      repeat (8) c = c[0] ? (c >> 1) ^ `MSR_CRC_POLY : c >> 1;
    end
    e = {e, c[7:0], c[15:8]};
    check_val(32'(u_msr_host_model.ans.size()), 32'(len));
    foreach (e[k]) check_val(u_msr_host_model.ans[k], e[k]);
  endtask : expect_frame

  task automatic eng_load(input logic [15:0] m, input logic [15:0] l, input logic [15:0] h);
    @(negedge MCLK_I);
    mix = m;
    glo = l;
    ghi = h;
    eng_ld = 1'b1;
    @(negedge MCLK_I);
    eng_ld = 1'b0;
  endtask : eng_load

  // Load border settings and position, then judge the registered status
  task automatic lim(input logic [7:0] t, input logic [7:0] s, input logic [31:0] p,
                     input logic [1:0] sw, input logic [2:0] exp);
    @(negedge MCLK_I);
    tlf = t;
    lsf = s;
    pos = p;
    {in_one, in_two} = sw;
    brd_ld = 1'b1;
    @(negedge MCLK_I);
    brd_ld = 1'b0;
    repeat (2) @(negedge MCLK_I);
    check_val({29'h0, at_l, at_r, stop}, {29'h0, exp});
  endtask : lim

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_unknown();
    u_msr_host_model.query(32'h73616568, 1'b0);
    check_val(32'(u_msr_host_model.ans.size()), 32'h0);
    $display("test_unknown done");
  endtask : test_unknown

  task automatic test_defaults();
    u_msr_host_model.query(`MSR_CMD_ENG_ADV, 1'b0);
    expect_frame(`MSR_CMD_ENG_ADV, '{8'h32, 8'h00, 8'hE8, 8'h03, 8'h21, 8'h00}, 54);
    $display("test_defaults done");
  endtask : test_defaults

  // Ratio at its top value loads; one above is dropped while gains still load
  task automatic test_eng_load();
    eng_load(16'h0064, 16'hFFFF, 16'h0000);
    eng_load(16'h0065, 16'h1234, 16'h5678);
    u_msr_host_model.query(`MSR_CMD_ENG_ADV, 1'b1);
    expect_frame(`MSR_CMD_ENG_ADV, '{8'h64, 8'h00, 8'h34, 8'h12, 8'h78, 8'h56}, 54);
    $display("test_eng_load done");
  endtask : test_eng_load

  task automatic test_border();
    lim(8'h0D, 8'h05, 32'h0, 2'b00, 3'b000);
    u_msr_host_model.query(`MSR_CMD_BORDER, 1'b1);
    expect_frame(`MSR_CMD_BORDER, '{8'h0D, 8'h05, 8'h9C, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h80,
                 8'h64, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h7F}, 26);
    $display("test_border done");
  endtask : test_border

  task automatic test_limits();
    lim(8'h03, 8'h00, 32'hFFFFFF38, 2'b11, 3'b101);
    lim(8'h03, 8'h00, 32'h000000C8, 2'b00, 3'b010);
    lim(8'h05, 8'h00, 32'hFFFFFF38, 2'b00, 3'b100);
    lim(8'h09, 8'h00, 32'h000000C8, 2'b00, 3'b011);
    lim(8'h03, 8'h00, 32'hFFFFFF9C, 2'b00, 3'b000);
    lim(8'h03, 8'h00, 32'hFFFFFF9B, 2'b00, 3'b101);
    lim(8'h05, 8'h00, 32'h00000065, 2'b00, 3'b011);
    lim(8'h01, 8'h00, 32'h0, 2'b11, 3'b000);
    lim(8'h06, 8'h00, 32'h0, 2'b10, 3'b101);
    lim(8'h06, 8'h01, 32'h0, 2'b10, 3'b011);
    lim(8'h00, 8'h06, 32'h0, 2'b01, 3'b100);
    lim(8'h00, 8'h04, 32'h0, 2'b10, 3'b110);
    $display("test_limits done");
  endtask : test_limits

  initial begin
    repeat (6) @(posedge MCLK_I);
    @(negedge MCLK_I);
    RST_N_I = 1'b1;
    test_unknown();
    test_defaults();
    test_eng_load();
    test_border();
    test_limits();
    finish_test();
  end
endmodule : testbench
